// *** hdl/reload_timer_pkg.sv ***
// Constants, field layout and bus carrier for the reloadable up/down timer.
// Assumes an 8-bit register port and a single system clock.
package reload_timer_pkg;

	// Register offsets; the count and reload values share one address
	localparam logic [7:0] MODE_OFFSET      = 8'hb4;
	localparam logic [7:0] COUNT_OFFSET     = 8'hb5;

	// Mode register field positions
	localparam int RELOAD_SELECT_POS        = 7;
	localparam int DIRECTION_CTRL_HI_POS    = 6;
	localparam int DIRECTION_CTRL_LO_POS    = 5;
	localparam int SOURCE_SELECT_LSB        = 0;
	localparam int SOURCE_SELECT_WIDTH      = 3;

	// Writable bits of the mode register; bits 4 and 3 are fixed at one
	localparam logic [7:0] MODE_WRITE_MASK  = 8'he7;
	localparam logic [7:0] MODE_FIXED_ONES  = 8'h18;
	localparam logic [7:0] MODE_RESET       = 8'h18;
	localparam logic [7:0] COUNT_RESET      = 8'h00;
	localparam logic [7:0] RELOAD_RESET     = 8'h00;
	localparam logic [7:0] UNMAPPED_READ    = 8'h00;

	// Prescaler: divide ratios are powers of two, given as exponents
	localparam int PRESCALE_WIDTH           = 13;
	localparam logic [3:0] DIV_EXP_0        = 4'hd;   // /8192
	localparam logic [3:0] DIV_EXP_1        = 4'hb;   // /2048
	localparam logic [3:0] DIV_EXP_2        = 4'h9;   // /512
	localparam logic [3:0] DIV_EXP_3        = 4'h6;   // /64
	localparam logic [3:0] DIV_EXP_4        = 4'h4;   // /16
	localparam logic [3:0] DIV_EXP_5        = 4'h2;   // /4
	localparam logic [3:0] DIV_EXP_6        = 4'h1;   // /2
	localparam logic [2:0] SOURCE_EXTERNAL  = 3'h7;

	// Count direction as decoded from the mode bits
	typedef enum logic [1:0] {
		DIR_UP,
		DIR_DOWN,
		DIR_PIN
	} direction_mode_t;

	// One register-port request
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_t;

endpackage

// *** hdl/timer_sync.sv ***
// Two-flop synchroniser for asynchronous level inputs.
// Assumes inputs change slower than one clock period.
module timer_sync
	import reload_timer_pkg::*;
#(
	parameter int WIDTH = 1
) (
	input  wire logic             i_clock,
	input  wire logic             i_rst_n,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);

	logic [WIDTH-1:0] meta_q;
	logic [WIDTH-1:0] sync_q;

	// First stage feeds only the second stage
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= i_async;
			sync_q <= meta_q;
		end
	end

	assign o_sync = sync_q;

endmodule

// *** hdl/timer_prescaler.sv ***
// Free-running clock prescaler giving one-cycle ticks at power-of-two rates.
// Assumes the select is stable or that one lost tick on a change is fine.
module timer_prescaler
	import reload_timer_pkg::*;
#(
	parameter int WIDTH = PRESCALE_WIDTH
) (
	input  wire logic       i_clock,
	input  wire logic       i_rst_n,
	input  wire logic [2:0] i_source_select,
	output logic            o_tick
);

	logic [WIDTH-1:0] div_q;
	logic             tick_q;

	// Exponent of the divide ratio for each source code
	function automatic logic [3:0] div_exp(input logic [2:0] sel);
		case (sel)
			3'h0:    div_exp = DIV_EXP_0;
			3'h1:    div_exp = DIV_EXP_1;
			3'h2:    div_exp = DIV_EXP_2;
			3'h3:    div_exp = DIV_EXP_3;
			3'h4:    div_exp = DIV_EXP_4;
			3'h5:    div_exp = DIV_EXP_5;
			default: div_exp = DIV_EXP_6;
		endcase
	endfunction

	// Low bits all ones marks the last cycle of each divided period
	function automatic logic period_end(input logic [WIDTH-1:0] cnt, input logic [3:0] e);
		logic [WIDTH:0] mask;
		mask = ({{WIDTH{1'b0}}, 1'b1} << e) - 1'b1;
		period_end = &(cnt | ~mask[WIDTH-1:0]);
	endfunction

	// Divider never stops, so changing the rate needs no restart
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			div_q <= '0;
		end else begin
			div_q <= div_q + 1'b1;
		end
	end

	// Registered tick keeps the counter path short
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			tick_q <= 1'b0;
		end else begin
			tick_q <= (i_source_select != SOURCE_EXTERNAL)
				&& period_end(div_q, div_exp(i_source_select));
		end
	end

	assign o_tick = tick_q;

endmodule

// *** hdl/reload_timer.sv ***
// Reloadable 8-bit up/down timer with a shared count/reload address.
// Assumes a register master that holds each strobe for one cycle only.
//
// Behaviour
// [RL1] Reading shared address returns live count
// [RL2] Writing shared address loads reload value
// [RL3] Reload select zero: free-running interval
// [RL4] Reload select one: reload on wrap
// [RL5] Mode bits pick direction and source
module reload_timer
	import reload_timer_pkg::*;
(
	input  wire logic     i_clock,
	input  wire logic     i_rst_n,
	input  wire reg_req_t i_req,
	output logic [7:0]    o_rdata,
	input  wire logic     i_direction_pin,
	input  wire logic     i_event,
	input  wire logic     i_event_falling,
	output logic [7:0]    o_count,
	output logic          o_wrap
);

	// Register state
	logic [7:0] mode_q;
	logic [7:0] live_count_q;
	logic [7:0] live_count_d;
	logic [7:0] reload_value_q;
	logic [7:0] rdata_q;
	logic       wrap_q;

	// Decoded mode fields
	logic            reload_select_bit;
	logic            direction_ctrl_hi;
	logic            direction_ctrl_lo;
	logic [2:0]      source_select;
	direction_mode_t dir_mode;

	// Synchronised pin levels and event edge detect
	logic [1:0] pins_sync;
	logic       direction_pin_s;
	logic       event_s;
	logic       event_prev_q;
	logic       event_edge;

	// Count enable sources
	logic       prescale_tick;
	logic       count_tick;
	logic       count_down;
	logic       wraps;

	// Address decode
	logic       hit_mode;
	logic       hit_count;

	assign hit_mode  = (i_req.addr == MODE_OFFSET);
	assign hit_count = (i_req.addr == COUNT_OFFSET);

	// Mode field extraction
	assign reload_select_bit = mode_q[RELOAD_SELECT_POS];
	assign direction_ctrl_hi = mode_q[DIRECTION_CTRL_HI_POS];
	assign direction_ctrl_lo = mode_q[DIRECTION_CTRL_LO_POS];
	assign source_select     = mode_q[SOURCE_SELECT_LSB +: SOURCE_SELECT_WIDTH];

	// Both pins come from outside the clock domain
	timer_sync #(
		.WIDTH (2)
	) u_pin_sync (
		.i_clock (i_clock),
		.i_rst_n (i_rst_n),
		.i_async ({i_direction_pin, i_event}),
		.o_sync  (pins_sync)
	);

	assign direction_pin_s = pins_sync[1];
	assign event_s         = pins_sync[0];

	// Internal clock divider for the seven internal sources
	timer_prescaler #(
		.WIDTH (PRESCALE_WIDTH)
	) u_prescaler (
		.i_clock         (i_clock),
		.i_rst_n         (i_rst_n),
		.i_source_select (source_select),
		.o_tick          (prescale_tick)
	);

	// Previous event level, read only after synchronisation
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			event_prev_q <= 1'b0;
		end else begin
			event_prev_q <= event_s;
		end
	end

	// Edge polarity of the external event is chosen by a plain input
	always_comb begin
		if (i_event_falling) begin
			event_edge = event_prev_q && !event_s;
		end else begin
			event_edge = !event_prev_q && event_s;
		end
	end

	// Source select: dividers or external events
	assign count_tick = (source_select == SOURCE_EXTERNAL) ? event_edge : prescale_tick; // RL5

	// Direction decode: 00 up, 01 down, 1x follows the pin
	always_comb begin
		if (direction_ctrl_hi) begin
			dir_mode = DIR_PIN; // RL5
		end else if (direction_ctrl_lo) begin
			dir_mode = DIR_DOWN; // RL5
		end else begin
			dir_mode = DIR_UP; // RL5
		end
	end

	// Pin high counts down, pin low counts up
	always_comb begin
		case (dir_mode)
			DIR_UP:   count_down = 1'b0;
			DIR_DOWN: count_down = 1'b1;
			DIR_PIN:  count_down = direction_pin_s; // RL5
			default:  count_down = 1'b0;
		endcase
	end

	// A wrap is leaving 8'hff upward or 8'h00 downward
	assign wraps = count_tick
		&& (count_down ? (live_count_q == 8'h00) : (live_count_q == 8'hff));

	// Next count value
	always_comb begin
		live_count_d = live_count_q;
		if (count_tick) begin
			if (wraps && reload_select_bit) begin
				live_count_d = reload_value_q; // RL4
			end else if (count_down) begin
				live_count_d = live_count_q - 8'h01; // RL3
			end else begin
				live_count_d = live_count_q + 8'h01; // RL3
			end
		end
	end

	// Live counter; software never writes it directly
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			live_count_q <= COUNT_RESET;
		end else begin
			live_count_q <= live_count_d;
		end
	end

	// Reload value takes every write to the shared address
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			reload_value_q <= RELOAD_RESET;
		end else if (i_req.wr && hit_count) begin
			reload_value_q <= i_req.wdata; // RL2
		end
	end

	// Mode register; reserved bits stay one whatever is written
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			mode_q <= MODE_RESET;
		end else if (i_req.wr && hit_mode) begin
			mode_q <= (i_req.wdata & MODE_WRITE_MASK) | MODE_FIXED_ONES;
		end
	end

	// Read data valid only in the cycle after the strobe
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rdata_q <= UNMAPPED_READ;
		end else if (!i_req.rd) begin
			rdata_q <= UNMAPPED_READ;
		end else if (hit_mode) begin
			rdata_q <= mode_q;
		end else if (hit_count) begin
			rdata_q <= live_count_q; // RL1
		end else begin
			rdata_q <= UNMAPPED_READ;
		end
	end

	// Wrap pulse, one cycle, in either timer mode
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			wrap_q <= 1'b0;
		end else begin
			wrap_q <= wraps;
		end
	end

	assign o_rdata = rdata_q;
	assign o_count = live_count_q;
	assign o_wrap  = wrap_q;

endmodule

// *** test/reload_timer_asserts.sv ***
// Checker for the reload timer register port and counter steps.
// Assumes a bind onto reload_timer; mode and reload are mirrored from writes.
module reload_timer_asserts
	import reload_timer_pkg::*;
(
	input  wire logic       i_clock,
	input  wire logic       i_rst_n,
	input  wire reg_req_t   i_req,
	input  wire logic [7:0] o_rdata,
	input  wire logic [7:0] o_count,
	input  wire logic       o_wrap
);
	logic [7:0] mode_q;
	logic [7:0] reload_q;
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);
	// Shadows of what software wrote, for expected values
	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			mode_q   <= MODE_RESET;
			reload_q <= RELOAD_RESET;
		end else if (i_req.wr && i_req.addr == MODE_OFFSET) begin
			mode_q <= (i_req.wdata & MODE_WRITE_MASK) | MODE_FIXED_ONES;
		end else if (i_req.wr && i_req.addr == COUNT_OFFSET) begin
			reload_q <= i_req.wdata;
		end
	end
	rdata_idle_a: assert property (!$past(i_req.rd) |-> o_rdata == 8'h00)
		else $error("read data not idle");
	read_count_a: assert property (i_req.rd && i_req.addr == COUNT_OFFSET |=>
		o_rdata == $past(o_count)) else $error("shared read is not live count");
	read_mode_a: assert property (i_req.rd && i_req.addr == MODE_OFFSET |=>
		o_rdata == $past(mode_q)) else $error("mode readback wrong");
	unmapped_a: assert property (i_req.rd && i_req.addr != MODE_OFFSET &&
		i_req.addr != COUNT_OFFSET |=> o_rdata == UNMAPPED_READ) else $error("unmapped read");
	// Mode held two cycles so a tick in flight at a change is not judged
	up_step_a: assert property ($changed(o_count) && mode_q == $past(mode_q, 2) &&
		mode_q[7:5] == 3'b000 |-> o_count == $past(o_count) + 8'h01) else $error("up step");
	down_step_a: assert property ($changed(o_count) && mode_q == $past(mode_q, 2) &&
		mode_q[7:5] == 3'b001 |-> o_count == $past(o_count) - 8'h01) else $error("down step");
	auto_reload_a: assert property ($changed(o_count) && mode_q == $past(mode_q, 2) &&
		mode_q[7:5] == 3'b101 && $past(o_count) == 8'h00 |-> o_count == reload_q)
		else $error("auto reload value");
	wrap_flag_a: assert property ($changed(o_count) && $past(o_count) == 8'hff &&
		o_count == 8'h00 |-> ##[0:1] o_wrap) else $error("no wrap pulse");
	cover property (o_wrap);
	cover property (mode_q[7] && $changed(o_count));
	cover property (i_req.rd && i_req.addr == COUNT_OFFSET);
endmodule

// *** test/tb_reload_timer.sv ***
// Self-checking bench for the reload timer through its register port.
// Assumes the checker compiled before; external events step the counter, except in t_rates where the internal dividers do.
module tb_reload_timer
	import reload_timer_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	logic       i_clock;
	logic       i_rst_n;
	reg_req_t   req;
	logic [7:0] o_rdata;
	logic       pin;
	logic       evt;
	logic       falling;
	logic [7:0] o_count;
	logic       o_wrap;
	logic       wrap_seen;
	int         err_count;
	int         compares;
	reload_timer u_dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_req(req), .o_rdata(o_rdata),
		.i_direction_pin(pin), .i_event(evt), .i_event_falling(falling), .o_count(o_count),
		.o_wrap(o_wrap));
	// Clock, 4 ns period
	initial begin
		i_clock = 1'b0;
		forever #2 i_clock = ~i_clock;
	end
	// Sticky record of any wrap pulse
	always @(posedge i_clock) begin
		if (o_wrap === 1'b1) wrap_seen <= 1'b1;
	end
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_clock);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge i_clock);
		req.wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge i_clock);
		req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge i_clock);
		req.rd <= 1'b0;
		#1 check(o_rdata, e);
	endtask
	// Wide pulses: the event is synced and edge detected inside
	task automatic pulse(input int n);
		repeat (n) begin
			@(posedge i_clock);
			evt <= 1'b1;
			repeat (5) @(posedge i_clock);
			evt <= 1'b0;
			repeat (5) @(posedge i_clock);
		end
	endtask
	task automatic t_reset();
		rd(MODE_OFFSET, MODE_RESET);
		rd(COUNT_OFFSET, COUNT_RESET);
		rd(8'ha0, UNMAPPED_READ);
	endtask
	task automatic t_shared();
		wr(COUNT_OFFSET, 8'h5a);
		rd(COUNT_OFFSET, 8'h00);
	endtask
	task automatic t_direction();
		wr(MODE_OFFSET, 8'h07);
		pulse(3);
		check(o_count, 8'h03);
		wr(MODE_OFFSET, 8'h27);
		pulse(4);
		check(o_count, 8'hff);
		@(posedge i_clock);
		pin <= 1'b1;
		wr(MODE_OFFSET, 8'h47);
		pulse(1);
		check(o_count, 8'hfe);
		@(posedge i_clock);
		pin <= 1'b0;
		pulse(2);
		check(o_count, 8'h00);
		check({7'h00, wrap_seen}, 8'h01);
	endtask
	task automatic t_auto();
		wr(MODE_OFFSET, 8'ha7);
		pulse(1);
		check(o_count, 8'h5a);
		wr(COUNT_OFFSET, 8'h10);
		rd(COUNT_OFFSET, 8'h5a);
		pulse(1);
		check(o_count, 8'h59);
		rd(MODE_OFFSET, 8'hbf);
	endtask
	// Falling-edge polarity: the rise alone must not count
	task automatic t_falling();
		wr(MODE_OFFSET, 8'h07);
		falling <= 1'b1;
		@(posedge i_clock);
		evt <= 1'b1;
		repeat (5) @(posedge i_clock);
		check(o_count, 8'h59);
		evt <= 1'b0;
		repeat (5) @(posedge i_clock);
		check(o_count, 8'h5a);
		falling <= 1'b0;
	endtask
	// Any window of whole divider periods holds exactly that many ticks
	task automatic rate(input logic [2:0] code, input logic [3:0] e, input int n);
		logic [7:0] c0;
		wr(MODE_OFFSET, {5'h00, code});
		repeat (2) @(posedge i_clock);
		#1 c0 = o_count;
		repeat (n << e) @(posedge i_clock);
		#1 check(o_count, 8'(c0 + n));
	endtask
	// Every internal source, up counting in interval mode
	task automatic t_rates();
		rate(3'h6, DIV_EXP_6, 20);
		rate(3'h5, DIV_EXP_5, 10);
		rate(3'h4, DIV_EXP_4, 4);
		rate(3'h3, DIV_EXP_3, 2);
		rate(3'h2, DIV_EXP_2, 1);
		rate(3'h1, DIV_EXP_1, 1);
		rate(3'h0, DIV_EXP_0, 1);
		wr(MODE_OFFSET, 8'h07);
	endtask
	task automatic give_verdict();
		$display("errors %0d, comparisons %0d", err_count, compares);
		if (err_count == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	initial begin
		err_count = 0;
		compares  = 0;
		wrap_seen = 1'b0;
		req       = '0;
		pin       = 1'b0;
		evt       = 1'b0;
		falling   = 1'b0;
		i_rst_n   = 1'b0;
		repeat (4) @(posedge i_clock);
		i_rst_n <= 1'b1;
		t_reset();
		t_shared();
		t_direction();
		t_auto();
		t_falling();
		t_rates();
		give_verdict();
	end
	// Tests take about eleven thousand cycles, mostly the slowest divider
	initial begin
		repeat (20000) @(posedge i_clock);
		err_count++;
		give_verdict();
	end
endmodule
bind reload_timer reload_timer_asserts u_chk (.i_clock(i_clock), .i_rst_n(i_rst_n),
	.i_req(i_req), .o_rdata(o_rdata), .o_count(o_count), .o_wrap(o_wrap));
